// ### logic/adc_ctrl_consts.svh
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH

// Clock and timing figures
`define ADC_MCLK_HZ          20000000
`define ADC_MCLK_NS          50
`define ADC_SAMPLE_NS        10000
`define ADC_SAMPLE_CYC       ((`ADC_SAMPLE_NS + `ADC_MCLK_NS - 1) / `ADC_MCLK_NS)
`define ADC_OSC_NORMAL_HZ    250000
`define ADC_OSC_FAST_HZ      500000
`define ADC_OSC_NORMAL_CYC   (`ADC_MCLK_HZ / `ADC_OSC_NORMAL_HZ)
`define ADC_OSC_FAST_CYC     (`ADC_MCLK_HZ / `ADC_OSC_FAST_HZ)
`define ADC_CONV_PERIODS     13
`define ADC_EXT_MIN_HZ       10000
`define ADC_EXT_TIMEOUT_CYC  (`ADC_MCLK_HZ / `ADC_EXT_MIN_HZ)

// Widths and positions
`define ADC_RESULT_W         10
`define ADC_EDGE_W           5
`define ADC_IDX_W            4
`define ADC_IDX_READY        4'h0
`define ADC_IDX_LAST         4'ha
`define ADC_IDX_SAT          4'hb
`define ADC_PIN_W            7
`define ADC_PIN_CE           0
`define ADC_PIN_CS_N         1
`define ADC_PIN_READ         2
`define ADC_PIN_BYTE         3
`define ADC_PIN_WORD         4
`define ADC_PIN_SPEED        5
`define ADC_PIN_EXTCLK       6
`define ADC_PIN_RESET        7'h02

`endif

// ### logic/adc_ctrl_pkg.sv
`include "adc_ctrl_consts.svh"

package adc_ctrl_pkg;

  typedef enum logic [1:0]
  {
    ST_IDLE    = 2'h0,
    ST_SAMPLE  = 2'h1,
    ST_CONVERT = 2'h2,
    ST_DONE    = 2'h3
  } conv_state_type;

  typedef logic [`ADC_RESULT_W-1:0] result_type;
  typedef logic [`ADC_EDGE_W-1:0]   edge_count_type;
  typedef logic [`ADC_IDX_W-1:0]    bit_index_type;

endpackage : adc_ctrl_pkg

// ### logic/sclk_edge_counter.sv
`timescale 1ns/10ps
`include "adc_ctrl_consts.svh"

// Counts falling shift-clock edges; count leaves as gray code
module sclk_edge_counter
(
  input  wire  logic                       sclk,
  input  wire  logic                       rst,
  output adc_ctrl_pkg::edge_count_type     edge_gray
);

  adc_ctrl_pkg::edge_count_type count_r;
  adc_ctrl_pkg::edge_count_type count_nxt;
  adc_ctrl_pkg::edge_count_type gray_r;

  assign count_nxt = count_r + `ADC_EDGE_W'h1;

  always_ff @(negedge sclk or posedge rst)
  begin
    if (rst)
    begin
      count_r <= '0;
      gray_r  <= '0;
    end
    else
    begin
      count_r <= count_nxt;
      gray_r  <= count_nxt ^ (count_nxt >> 1);
    end
  end

  assign edge_gray = gray_r;

endmodule : sclk_edge_counter

// ### logic/sar_adc_host_interface.sv
// Notes on behaviour
// - Start only on rising edge of combined condition.
// - Held start condition never restarts conversion.
// - Byte select at start picks 10/8 bits.
// - 8-bit result: upper bits, two LSBs zero.
// - Converting: done flag high, parallel lines float.
// - Converting: serial low if selected, else floats.
// - Completion: done low, result into both paths.
// - Parallel and serial reads usable together.
// - Word format high: all ten lines driven.
// - Byte mode, select low: eight MSBs.
// - Byte mode, select high: two LSBs, zeros.
// - Track input 10 us, then sample.
// - Internal oscillator: 13 periods after sampling.
// - External clock activity blocks internal oscillator.
// - Falling shift clock edges send MSB first.
// - Zeros after LSB until select rises.
// - Select falling edge reloads serial result.
// - Read selector high reads, low converts.
// - Serial output rises at end: data ready.
// - Speed select low doubles oscillator rate.
`timescale 1ns/10ps
`include "adc_ctrl_consts.svh"

module sar_adc_host_interface
(
  input  wire  logic                       MCLK,
  input  wire  logic                       RST,
  input  wire  logic                       CHIP_ENABLE,
  input  wire  logic                       CHIP_SELECT_N,
  input  wire  logic                       READ_SELECT,
  input  wire  logic                       BYTE_SELECT,
  input  wire  logic                       WORD_FORMAT_SELECT,
  input  wire  logic                       OSC_SPEED_SELECT,
  input  wire  logic                       EXTERNAL_CONVERSION_CLOCK,
  input  wire  logic                       SHIFT_CLOCK,
  input  wire  adc_ctrl_pkg::result_type   ANALOG_CODE,
  output adc_ctrl_pkg::result_type         DATA_OUT,
  output logic [`ADC_RESULT_W-1:0]         DATA_OE,
  output logic                             SERIAL_OUT,
  output logic                             SERIAL_OE,
  output logic                             CONVERSION_DONE_N,
  output logic                             INT_OSC_RUN,
  output logic                             EXT_CLOCK_PRESENT
);

  localparam int SAMP_I = `ADC_SAMPLE_CYC;
  localparam logic [7:0] SAMPLE_LAST = 8'(`ADC_SAMPLE_CYC - 1);
  localparam logic [6:0] OSC_NORMAL_LAST = 7'(`ADC_OSC_NORMAL_CYC - 1);
  localparam logic [6:0] OSC_FAST_LAST = 7'(`ADC_OSC_FAST_CYC - 1);
  localparam logic [3:0] PERIOD_LAST = 4'(`ADC_CONV_PERIODS - 1);
  localparam logic [11:0] EXT_TIMEOUT = 12'(`ADC_EXT_TIMEOUT_CYC);

  adc_ctrl_pkg::conv_state_type state_r;
  adc_ctrl_pkg::result_type     result_r;
  adc_ctrl_pkg::result_type     code_meta_r;
  adc_ctrl_pkg::result_type     code_sync_r;
  adc_ctrl_pkg::edge_count_type edge_gray;
  adc_ctrl_pkg::edge_count_type gray_meta_r;
  adc_ctrl_pkg::edge_count_type gray_sync_r;
  adc_ctrl_pkg::edge_count_type seen_r;
  adc_ctrl_pkg::edge_count_type edge_diff;
  adc_ctrl_pkg::bit_index_type  bit_idx_r;
  adc_ctrl_pkg::result_type     data_nxt;
  logic [`ADC_RESULT_W-1:0]     oe_nxt;
  logic [`ADC_PIN_W-1:0]        pin_meta_r;
  logic [`ADC_PIN_W-1:0]        pin_sync_r;
  logic [`ADC_PIN_W-1:0]        pin_raw;
  logic [7:0]                   samp_cnt_r;
  logic [6:0]                   div_cnt_r;
  logic [3:0]                   period_cnt_r;
  logic [11:0]                  ext_idle_r;
  logic [5:0]                   idx_sum;
  logic                         ce_s;
  logic                         cs_n_s;
  logic                         read_s;
  logic                         ext_s;
  logic                         start_cond;
  logic                         start_cond_prev_r;
  logic                         start_pulse;
  logic                         cs_prev_r;
  logic                         cs_fall;
  logic                         ext_prev_r;
  logic                         ext_rise;
  logic                         byte_mode_r;
  logic                         use_ext_r;
  logic                         have_result_r;
  logic                         busy;
  logic                         sampling;
  logic                         period_end;
  logic                         done_evt;
  logic                         read_en;
  logic                         reload;

  // Shift-clock domain edge counter
  sclk_edge_counter u_edge_counter
  (
    .sclk      (SHIFT_CLOCK),
    .rst       (RST),
    .edge_gray (edge_gray)
  );

  function automatic adc_ctrl_pkg::edge_count_type gray_to_bin
  (
    input adc_ctrl_pkg::edge_count_type g
  );
    adc_ctrl_pkg::edge_count_type b;
    b[`ADC_EDGE_W-1] = g[`ADC_EDGE_W-1];
    for (int i = `ADC_EDGE_W-2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray_to_bin

  assign pin_raw = {EXTERNAL_CONVERSION_CLOCK, OSC_SPEED_SELECT, WORD_FORMAT_SELECT,
                    BYTE_SELECT, READ_SELECT, CHIP_SELECT_N, CHIP_ENABLE};

  // Two-flop synchronisers for all pins and the edge count
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      pin_meta_r  <= `ADC_PIN_RESET;
      pin_sync_r  <= `ADC_PIN_RESET;
      code_meta_r <= '0;
      code_sync_r <= '0;
      gray_meta_r <= '0;
      gray_sync_r <= '0;
    end
    else
    begin
      pin_meta_r  <= pin_raw;
      pin_sync_r  <= pin_meta_r;
      code_meta_r <= ANALOG_CODE;
      code_sync_r <= code_meta_r;
      gray_meta_r <= edge_gray;
      gray_sync_r <= gray_meta_r;
    end
  end

  assign ce_s   = pin_sync_r[`ADC_PIN_CE];
  assign cs_n_s = pin_sync_r[`ADC_PIN_CS_N];
  assign read_s = pin_sync_r[`ADC_PIN_READ];
  assign ext_s  = pin_sync_r[`ADC_PIN_EXTCLK];

  assign start_cond  = ce_s & ~cs_n_s & ~read_s;
  assign start_pulse = start_cond & ~start_cond_prev_r;
  assign cs_fall     = ~cs_n_s & cs_prev_r;
  assign ext_rise    = ext_s & ~ext_prev_r;
  assign busy        = (state_r == adc_ctrl_pkg::ST_SAMPLE) | (state_r == adc_ctrl_pkg::ST_CONVERT);
  assign sampling    = state_r == adc_ctrl_pkg::ST_SAMPLE;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      start_cond_prev_r <= 1'h0;
      cs_prev_r         <= 1'h1;
      ext_prev_r        <= 1'h0;
    end
    else
    begin
      start_cond_prev_r <= start_cond;
      cs_prev_r         <= cs_n_s;
      ext_prev_r        <= ext_s;
    end
  end

  // External clock activity: present while edges come faster than the timeout
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      ext_idle_r <= EXT_TIMEOUT;
    end
    else if (ext_s != ext_prev_r)
    begin
      ext_idle_r <= '0;
    end
    else if (ext_idle_r != EXT_TIMEOUT)
    begin
      ext_idle_r <= ext_idle_r + 12'h001;
    end
  end

  assign EXT_CLOCK_PRESENT = ext_idle_r != EXT_TIMEOUT;

  // One conversion period: external rising edge or internal divider wrap
  assign period_end = use_ext_r ? ext_rise :
                      (div_cnt_r == (pin_sync_r[`ADC_PIN_SPEED] ? OSC_NORMAL_LAST
                                                                  : OSC_FAST_LAST));
  assign done_evt = (state_r == adc_ctrl_pkg::ST_CONVERT) & period_end &
                    (period_cnt_r == PERIOD_LAST) & ~start_pulse;

  // Conversion sequencer
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      state_r      <= adc_ctrl_pkg::ST_IDLE;
      samp_cnt_r   <= '0;
      div_cnt_r    <= '0;
      period_cnt_r <= '0;
      byte_mode_r  <= 1'h0;
      use_ext_r    <= 1'h0;
      result_r     <= '0;
    end
    else if (start_pulse)
    begin
      state_r     <= adc_ctrl_pkg::ST_SAMPLE;
      samp_cnt_r  <= '0;
      byte_mode_r <= pin_sync_r[`ADC_PIN_BYTE];
    end
    else
    begin
      case (state_r)
        adc_ctrl_pkg::ST_SAMPLE:
        begin
          samp_cnt_r <= samp_cnt_r + 8'h01;
          if (samp_cnt_r == SAMPLE_LAST)
          begin
            state_r      <= adc_ctrl_pkg::ST_CONVERT;
            use_ext_r    <= EXT_CLOCK_PRESENT;
            div_cnt_r    <= '0;
            period_cnt_r <= '0;
            result_r     <= byte_mode_r ? {code_sync_r[`ADC_RESULT_W-1:2], 2'h0}
                            : code_sync_r;
          end
        end
        adc_ctrl_pkg::ST_CONVERT:
        begin
          div_cnt_r <= (period_end || use_ext_r) ? 7'h00 : div_cnt_r + 7'h01;
          if (done_evt)
          begin
            state_r <= adc_ctrl_pkg::ST_DONE;
          end
          else if (period_end)
          begin
            period_cnt_r <= period_cnt_r + 4'h1;
          end
        end
        adc_ctrl_pkg::ST_IDLE,
        adc_ctrl_pkg::ST_DONE:
        begin
          samp_cnt_r <= '0;
        end
        default:
        begin
          state_r <= adc_ctrl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign INT_OSC_RUN = (state_r == adc_ctrl_pkg::ST_CONVERT) & ~use_ext_r;

  // End flag and result availability
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      CONVERSION_DONE_N <= 1'h1;
      have_result_r     <= 1'h0;
    end
    else if (start_pulse)
    begin
      CONVERSION_DONE_N <= 1'h1;
      have_result_r     <= 1'h0;
    end
    else if (done_evt)
    begin
      CONVERSION_DONE_N <= 1'h0;
      have_result_r     <= 1'h1;
    end
  end

  // Serial position: 0 shows ready high, 1..10 MSB..LSB, then zeros
  assign edge_diff = gray_to_bin(gray_sync_r) - seen_r;
  assign idx_sum   = {2'h0, bit_idx_r} + {1'h0, edge_diff};
  assign reload    = done_evt | (cs_fall & have_result_r & ~busy);

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      seen_r    <= '0;
      bit_idx_r <= `ADC_IDX_READY;
    end
    else
    begin
      seen_r <= gray_to_bin(gray_sync_r);
      if (reload)
      begin
        bit_idx_r <= `ADC_IDX_READY;
      end
      else if (have_result_r && !busy && !cs_n_s)
      begin
        bit_idx_r <= idx_sum > {2'h0, `ADC_IDX_SAT} ? `ADC_IDX_SAT
                     : idx_sum[`ADC_IDX_W-1:0];
      end
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      SERIAL_OUT <= 1'h0;
      SERIAL_OE  <= 1'h0;
    end
    else
    begin
      SERIAL_OE <= ~cs_n_s;
      if (busy || !have_result_r || reload)
      begin
        SERIAL_OUT <= done_evt;
      end
      else if (bit_idx_r == `ADC_IDX_READY)
      begin
        SERIAL_OUT <= 1'h1;
      end
      else if (bit_idx_r <= `ADC_IDX_LAST)
      begin
        SERIAL_OUT <= result_r[`ADC_IDX_LAST - bit_idx_r];
      end
      else
      begin
        SERIAL_OUT <= 1'h0;
      end
    end
  end

  // Parallel read port
  assign read_en = ce_s & ~cs_n_s & read_s & ~busy;

  always_comb
  begin
    data_nxt = '0;
    oe_nxt   = '0;
    if (read_en && pin_sync_r[`ADC_PIN_WORD])
    begin
      data_nxt = result_r;
      oe_nxt   = '1;
    end
    else if (read_en && !pin_sync_r[`ADC_PIN_BYTE])
    begin
      data_nxt[`ADC_RESULT_W-1:2] = result_r[`ADC_RESULT_W-1:2];
      oe_nxt[`ADC_RESULT_W-1:2]   = '1;
    end
    else if (read_en)
    begin
      data_nxt[`ADC_RESULT_W-1:`ADC_RESULT_W-2] = result_r[1:0];
      oe_nxt[`ADC_RESULT_W-1:2]                 = '1;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      DATA_OUT <= '0;
      DATA_OE  <= '0;
    end
    else
    begin
      DATA_OUT <= data_nxt;
      DATA_OE  <= oe_nxt;
    end
  end

  property p_start_launch;
    @(posedge MCLK) disable iff (RST) start_pulse |=> state_r == adc_ctrl_pkg::ST_SAMPLE;
  endproperty
  a_start_launch: assert property (p_start_launch) else $error("start edge not launched");

  property p_no_restart;
    @(posedge MCLK) disable iff (RST) (start_cond && $past(start_cond) && !busy) |=> !busy;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("held condition restarted");

  property p_byte_capture;
    @(posedge MCLK) disable iff (RST)
      start_pulse |=> byte_mode_r == $past(pin_sync_r[`ADC_PIN_BYTE]);
  endproperty
  a_byte_capture: assert property (p_byte_capture) else $error("byte select not captured");

  property p_short_zero;
    @(posedge MCLK) disable iff (RST) (done_evt && byte_mode_r) |=> result_r[1:0] == 2'h0;
  endproperty
  a_short_zero: assert property (p_short_zero) else $error("8-bit result LSBs not zero");

  property p_busy_quiet;
    @(posedge MCLK) disable iff (RST)
      (busy && $past(busy)) |-> CONVERSION_DONE_N && DATA_OE == '0 && !SERIAL_OUT;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("outputs active in conversion");

  sequence s_sample_entry;
    !sampling ##1 sampling;
  endsequence

  property p_sample_time;
    @(posedge MCLK) disable iff (RST || start_pulse)
      s_sample_entry |-> ##[SAMP_I:SAMP_I] state_r == adc_ctrl_pkg::ST_CONVERT;
  endproperty
  a_sample_time: assert property (p_sample_time) else $error("sampling length wrong");

  property p_done_flag;
    @(posedge MCLK) disable iff (RST)
      done_evt |=> !CONVERSION_DONE_N && bit_idx_r == `ADC_IDX_READY ##1 SERIAL_OUT;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("completion not flagged");

  property p_osc_stop;
    @(posedge MCLK) disable iff (RST) $fell(INT_OSC_RUN) && !$past(start_pulse)
      |-> state_r == adc_ctrl_pkg::ST_DONE && $past(period_cnt_r) == PERIOD_LAST;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator periods wrong");

  property p_zero_tail;
    @(posedge MCLK) disable iff (RST)
      (bit_idx_r == `ADC_IDX_SAT && $past(bit_idx_r) == `ADC_IDX_SAT && !busy) |=> !SERIAL_OUT;
  endproperty
  a_zero_tail: assert property (p_zero_tail) else $error("serial tail not zero");

  property p_cs_reload;
    @(posedge MCLK) disable iff (RST)
      (cs_fall && have_result_r && !busy) |=> bit_idx_r == `ADC_IDX_READY;
  endproperty
  a_cs_reload: assert property (p_cs_reload) else $error("select fall did not reload");

endmodule : sar_adc_host_interface

// ### sim/host_link_model.sv
`timescale 1ns/10ps

// Host side: shift-clock pulses on request and an optional conversion clock
module host_link_model
#(
  parameter real EXT_HALF_NS = 2000.0,
  parameter real EXT_HOLD_NS = 11000.0
)
(
  input  wire logic ext_enable,
  input  wire logic shift_request,
  input  wire logic conv_request,
  output logic      shift_clock,
  output logic      ext_clock
);
  logic ext_raw;
  logic holding;

  initial
  begin
    shift_clock = 1'h0;
    ext_raw     = 1'h0;
    holding     = 1'h0;
  end

  assign ext_clock = ext_raw | holding;

  // Held high from each request through the sampling window
  always @(posedge conv_request)
  begin
    if (ext_enable)
    begin
      holding = 1'h1;
      #EXT_HOLD_NS;
      holding = 1'h0;
    end
  end

  // One 7.5 ns high pulse per request, idle low otherwise
  always @(posedge shift_request)
  begin
    shift_clock = 1'h1;
    #7.5;
    shift_clock = 1'h0;
  end

  // 250 kHz while enabled, grounded otherwise
  always
  begin
    if (ext_enable)
    begin
      #EXT_HALF_NS;
      ext_raw = ~ext_raw;
    end
    else
    begin
      ext_raw = 1'h0;
      @(ext_enable);
    end
  end
endmodule : host_link_model

// ### sim/tb_sar_adc_host_interface.sv
`timescale 1ns/10ps
`include "adc_ctrl_consts.svh"

module tb_sar_adc_host_interface;
  typedef struct packed
  {
    logic [9:0] code;
    logic       conv8;
    logic       word;
    logic       bsel;
    logic       speed;
  } row_type;

  logic                     mclk;
  logic                     rst;
  logic                     ce;
  logic                     cs_n;
  logic                     rd;
  logic                     bsel;
  logic                     word;
  logic                     speed;
  logic                     ext_en;
  logic                     shift_req;
  logic                     sclk;
  logic                     ext_clk;
  adc_ctrl_pkg::result_type code_in;
  adc_ctrl_pkg::result_type data_out;
  logic [9:0]               data_oe;
  logic                     ser_out;
  logic                     ser_oe;
  logic                     done_n;
  logic                     osc_run;
  logic                     ext_present;
  int                       err_total;
  int                       compares;
  int                       n;
  logic                     osc;
  logic                     ok;
  row_type                  rows [6] = '{
    '{10'h2b5, 1'h0, 1'h1, 1'h0, 1'h1}, '{10'h2b5, 1'h0, 1'h1, 1'h1, 1'h0},
    '{10'h2b5, 1'h0, 1'h0, 1'h0, 1'h1}, '{10'h2b5, 1'h0, 1'h0, 1'h1, 1'h0},
    '{10'h2b7, 1'h1, 1'h1, 1'h0, 1'h1}, '{10'h1ff, 1'h1, 1'h0, 1'h1, 1'h0}};

  sar_adc_host_interface sar_adc_host_interface_i
  (
    .MCLK                      (mclk),
    .RST                       (rst),
    .CHIP_ENABLE               (ce),
    .CHIP_SELECT_N             (cs_n),
    .READ_SELECT               (rd),
    .BYTE_SELECT               (bsel),
    .WORD_FORMAT_SELECT        (word),
    .OSC_SPEED_SELECT          (speed),
    .EXTERNAL_CONVERSION_CLOCK (ext_clk),
    .SHIFT_CLOCK               (sclk),
    .ANALOG_CODE               (code_in),
    .DATA_OUT                  (data_out),
    .DATA_OE                   (data_oe),
    .SERIAL_OUT                (ser_out),
    .SERIAL_OE                 (ser_oe),
    .CONVERSION_DONE_N         (done_n),
    .INT_OSC_RUN               (osc_run),
    .EXT_CLOCK_PRESENT         (ext_present)
  );

  host_link_model host_link_model_i
  (
    .ext_enable    (ext_en),
    .shift_request (shift_req),
    .conv_request  (ce & ~cs_n & ~rd),
    .shift_clock   (sclk),
    .ext_clock     (ext_clk)
  );

  initial
  begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic wait_cyc(input int cyc);
    repeat (cyc) @(negedge mclk);
  endtask : wait_cyc

  // Start from the current pin state, count cycles until the end flag falls
  task automatic convert(input logic [9:0] code, input logic conv8);
    ce = 1'h1;
    cs_n = 1'h0;
    rd = 1'h0;
    bsel = conv8;
    code_in = code;
    n = 0;
    osc = 1'h0;
    ok = 1'h1;
    while (n < 3000 && !(n > 6 && done_n === 1'h0))
    begin
      @(negedge mclk);
      n++;
      osc = osc | (osc_run === 1'h1);
      if (n == 20)
        bsel = ~conv8;
      if (n > 8 && done_n === 1'h1)
        ok = ok & (data_oe === 10'h000) & (ser_out === 1'h0) & (ser_oe === 1'h1);
    end
    if (n >= 3000)
    begin
      check("conversion end", 10'h001, 10'h000);
      report_and_stop();
    end
  endtask : convert

  task automatic check_time(input int lo);
    check("conversion time", 10'h001, {9'h000, n >= lo && n <= lo + 50});
  endtask : check_time

  task automatic par_read(input row_type r);
    adc_ctrl_pkg::result_type res;
    adc_ctrl_pkg::result_type exp_d;
    res = r.conv8 ? {r.code[9:2], 2'h0} : r.code;
    exp_d = r.word ? res : (r.bsel ? {res[1:0], 8'h00} : {res[9:2], 2'h0});
    word = r.word;
    bsel = r.bsel;
    rd = 1'h1;
    wait_cyc(4);
    check("parallel enables", r.word ? 10'h3ff : 10'h3fc, data_oe);
    check("parallel data", exp_d, data_out & data_oe);
  endtask : par_read

  task automatic shift_one;
    shift_req = 1'h1;
    wait_cyc(1);
    shift_req = 1'h0;
    wait_cyc(5);
  endtask : shift_one

  initial
  begin
    {ce, bsel, ext_en, shift_req, code_in} = '0;
    {rst, cs_n, rd, word, speed} = 5'h1f;
    err_total = 0;
    compares = 0;
    wait_cyc(4);
    rst = 1'h0;
    check("end flag after reset", 10'h001, {9'h000, done_n});
    check("enables after reset", 10'h000, {data_oe[9:1], ser_oe});
    foreach (rows[i])
    begin
      speed = rows[i].speed;
      convert(rows[i].code, rows[i].conv8);
      check_time(rows[i].speed ? 1230 : 710);
      check("quiet while busy", 10'h001, {9'h000, ok});
      check("oscillator ran", 10'h001, {9'h000, osc});
      check("serial ready", 10'h001, {9'h000, ser_out});
      par_read(rows[i]);
    end
    speed = 1'h1;
    convert(10'h155, 1'h0);
    wait_cyc(400);
    check("held request", 10'h000, {9'h000, done_n});
    check("no drive on request", 10'h000, data_oe);
    word = 1'h1;
    rd = 1'h1;
    wait_cyc(4);
    for (int i = 0; i < 12; i++)
    begin
      shift_one();
      ok = i < 10 && ((10'h155 >> (9 - i)) & 10'h001) != 10'h000;
      check("serial bit", {9'h000, ok}, {9'h000, ser_out});
    end
    check("parallel beside serial", 10'h155, data_out);
    cs_n = 1'h1;
    wait_cyc(4);
    check("unselected enables", 10'h000, {data_oe[9:1], ser_oe});
    cs_n = 1'h0;
    wait_cyc(5);
    check("reload ready", 10'h001, {9'h000, ser_out});
    shift_one();
    check("reload first bit", 10'h000, {9'h000, ser_out});
    ce = 1'h0;
    rd = 1'h0;
    cs_n = 1'h1;
    wait_cyc(4);
    cs_n = 1'h0;
    wait_cyc(20);
    check("disabled ignores", 10'h000, {data_oe[9:1], done_n});
    convert(10'h3ff, 1'h1);
    check_time(1230);
    par_read('{10'h3ff, 1'h1, 1'h1, 1'h0, 1'h1});
    cs_n = 1'h1;
    wait_cyc(4);
    convert(10'h0f0, 1'h0);
    check_time(1230);
    rd = 1'h1;
    wait_cyc(4);
    rd = 1'h0;
    wait_cyc(300);
    rd = 1'h1;
    wait_cyc(4);
    check("read while converting", 10'h001, {data_oe[9:1], done_n});
    convert(10'h30c, 1'h0);
    check_time(1230);
    rd = 1'h1;
    ext_en = 1'h1;
    wait_cyc(400);
    convert(10'h0aa, 1'h0);
    check_time(1230);
    check("no internal oscillator", 10'h000, {9'h000, osc});
    check("external clock seen", 10'h001, {9'h000, ext_present});
    par_read('{10'h0aa, 1'h0, 1'h1, 1'h0, 1'h1});
    ext_en = 1'h0;
    report_and_stop();
  end
endmodule : tb_sar_adc_host_interface
